// ---- design/conv_result_port.sv ----
// Conversion result output port: parallel, byte and dual-line serial.
// Assumes host pins are asynchronous; results arrive on a valid/ready source.
// Notes on behaviour
// RULE_01 - Strap low: all sixteen lanes driven only while chip select and read strobe are low, else released.
// RULE_02 - Byte mode: each result goes out over the low eight lanes in two read strobes.
// RULE_03 - Byte mode: each byte has its top bit on lane 7 and its bottom bit on lane 0.
// RULE_04 - Strap high with byte select low selects serial mode.
// RULE_05 - Strap high with byte select high selects byte mode.
// RULE_06 - Serial mode: lane 7 is serial output A and lane 8 is serial output B.
// RULE_07 - Byte mode: high byte first when high_byte_first is 1, else low byte first.
// RULE_08 - Reference select high enables the internal reference, low disables it.
// RULE_09 - Serial mode: chip select fall releases both outputs with the top bit; each clock rise shifts.
// RULE_10 - Serial mode: flag rises at chip select fall and drops at the 16th clock fall after it.
// RULE_11 - Parallel: flag rises on the channel one read fall, drops on the next; released while deselected.
`timescale 1ns/100ps
`default_nettype none
module conv_result_port
    import conv_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic cs_n_i,
    input wire logic read_strobe_i,
    input wire logic interface_select_i,
    input wire logic ref_select_i,
    input wire logic [RESULT_BITS-1:0] parallel_output_bus_i,
    output logic [RESULT_BITS-1:0] parallel_output_bus_o,
    output logic [RESULT_BITS-1:0] parallel_output_bus_oe_o,
    output logic first_channel_flag_o,
    output logic first_channel_flag_oe_o,
    output logic internal_ref_en_o,
    input wire logic result_valid_i,
    output logic result_ready_o,
    input wire result_word_t result_i
);
    port_state_t r, next_r;
    logic fifo_valid, pop;
    result_word_t word;
    logic cs_fall, rd_fall, rd_rise;

    function automatic mode_t mode_of(input logic sel, input logic bsel);
        if (!sel) begin
            return MODE_PAR;
        end else if (bsel) begin
            return MODE_BYTE;
        end
        return MODE_SER;
    endfunction

    // ************************************************************
    // Result buffer
    // ************************************************************
    result_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(result_valid_i),
        .in_ready_o(result_ready_o),
        .in_data_i(result_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .out_data_o(word)
    );

    assign cs_fall = r.cs_d && !r.cs_s2;
    assign rd_fall = r.rd_d && !r.rd_s2;
    assign rd_rise = !r.rd_d && r.rd_s2;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_r = r;
        pop = 1'b0;
        next_r.cs_s1 = cs_n_i;
        next_r.cs_s2 = r.cs_s1;
        next_r.cs_d = r.cs_s2;
        next_r.rd_s1 = read_strobe_i;
        next_r.rd_s2 = r.rd_s1;
        next_r.rd_d = r.rd_s2;
        next_r.sel_s1 = interface_select_i;
        next_r.sel_s2 = r.sel_s1;
        next_r.hbf_s1 = parallel_output_bus_i[HIGH_FIRST_LANE];
        next_r.hbf_s2 = r.hbf_s1;
        next_r.bsel_s1 = parallel_output_bus_i[BYTE_SEL_LANE];
        next_r.bsel_s2 = r.bsel_s1;
        next_r.ref_s1 = ref_select_i;
        next_r.ref_s2 = r.ref_s1;
        next_r.ref_en = r.ref_s2; // [RULE_08]
        if (r.cs_s2) begin
            // Mode follows the straps only between frames
            next_r.mode = mode_of(r.sel_s2, r.bsel_s2); // [RULE_04] [RULE_05]
            next_r.phase = 1'b0;
            next_r.load_b = 1'b0;
            next_r.bus_oe = LANES_NONE; // [RULE_01]
            next_r.flag = 1'b0;
            next_r.flag_oe = 1'b0; // [RULE_11]
        end else begin
            next_r.flag_oe = 1'b1;
            case (r.mode)
                MODE_PAR: begin
                    next_r.bus_oe = r.rd_s2 ? LANES_NONE : LANES_ALL; // [RULE_01]
                    if (rd_fall) begin
                        pop = fifo_valid;
                        next_r.bus = fifo_valid ? word.data : '0;
                        next_r.flag = fifo_valid && word.channel_one; // [RULE_11]
                    end
                end
                MODE_BYTE: begin
                    next_r.bus_oe = r.rd_s2 ? LANES_NONE : LANES_BYTE; // [RULE_02]
                    if (rd_fall && !r.phase) begin
                        pop = fifo_valid;
                        next_r.shift_a = fifo_valid ? word.data : '0;
                        next_r.bus = '0;
                        next_r.bus[7:0] = !fifo_valid ? 8'h00 :
                            r.hbf_s2 ? word.data[15:8] : word.data[7:0]; // [RULE_07] [RULE_03]
                        next_r.flag = fifo_valid && word.channel_one;
                        next_r.phase = 1'b1;
                    end else if (rd_fall) begin
                        next_r.bus[7:0] = r.hbf_s2 ? r.shift_a[7:0] : r.shift_a[15:8]; // [RULE_07] [RULE_02]
                        next_r.flag = 1'b0;
                        next_r.phase = 1'b0;
                    end
                end
                MODE_SER: begin
                    next_r.bus_oe = LANES_SERIAL; // [RULE_06]
                    if (cs_fall) begin
                        pop = fifo_valid;
                        next_r.shift_a = fifo_valid ? word.data : '0;
                        next_r.bus[SERIAL_A_LANE] = fifo_valid && word.data[15]; // [RULE_09]
                        next_r.flag = fifo_valid && word.channel_one; // [RULE_10]
                        next_r.fall_count = '0;
                        next_r.load_b = 1'b1;
                    end else begin
                        if (r.load_b) begin
                            // Second result of the frame goes to output B
                            pop = fifo_valid;
                            next_r.load_b = 1'b0;
                            next_r.shift_b = fifo_valid ? word.data : '0;
                            next_r.bus[SERIAL_B_LANE] = fifo_valid && word.data[15]; // [RULE_06]
                        end
                        if (rd_rise) begin
                            next_r.shift_a = {r.shift_a[14:0], 1'b0}; // [RULE_09]
                            next_r.shift_b = {r.shift_b[14:0], 1'b0};
                            next_r.bus[SERIAL_A_LANE] = r.shift_a[14];
                            next_r.bus[SERIAL_B_LANE] = r.shift_b[14];
                        end
                        if (rd_fall) begin
                            next_r.fall_count = r.fall_count + 5'h01;
                            if (r.fall_count == SERIAL_LAST_FALL) begin
                                next_r.flag = 1'b0; // [RULE_10]
                            end
                        end
                    end
                end
                default: begin
                    next_r.mode = MODE_PAR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= PORT_STATE_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign parallel_output_bus_o = r.bus;
    assign parallel_output_bus_oe_o = r.bus_oe;
    assign first_channel_flag_o = r.flag;
    assign first_channel_flag_oe_o = r.flag_oe;
    assign internal_ref_en_o = r.ref_en;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence byte_first_read;
        r.mode == MODE_BYTE && !r.cs_s2 && rd_fall && !r.phase && fifo_valid && r.hbf_s2;
    endsequence

    sequence serial_frame_start;
        r.mode == MODE_SER && !r.cs_s2 && cs_fall && fifo_valid;
    endsequence

    par_drive_a: assert property (r.mode == MODE_PAR && !r.cs_s2 && !r.rd_s2 |=> // [RULE_01]
        parallel_output_bus_oe_o == LANES_ALL) else $error("parallel lanes not driven");
    par_release_a: assert property (r.mode == MODE_PAR && (r.cs_s2 || r.rd_s2) |=> // [RULE_01]
        parallel_output_bus_oe_o == LANES_NONE) else $error("parallel lanes not released");
    byte_lanes_a: assert property (r.mode == MODE_BYTE && !r.cs_s2 |=> // [RULE_02]
        parallel_output_bus_oe_o[15:8] == 8'h00) else $error("byte mode drives upper lanes");
    byte_order_a: assert property (byte_first_read |=> // [RULE_07]
        parallel_output_bus_o[7:0] == $past(word.data[15:8])) else $error("byte order wrong");
    ser_select_a: assert property (r.cs_s2 && r.sel_s2 && !r.bsel_s2 |=> // [RULE_04]
        r.mode == MODE_SER) else $error("serial mode not selected");
    byte_select_a: assert property (r.cs_s2 && r.sel_s2 && r.bsel_s2 |=> // [RULE_05]
        r.mode == MODE_BYTE) else $error("byte mode not selected");
    ser_msb_a: assert property (serial_frame_start |=> // [RULE_09]
        parallel_output_bus_oe_o == LANES_SERIAL
        && parallel_output_bus_o[SERIAL_A_LANE] == $past(word.data[15])) else $error("serial msb missing");
    ser_shift_a: assert property (r.mode == MODE_SER && !r.cs_s2 && !cs_fall && rd_rise |=> // [RULE_09]
        parallel_output_bus_o[SERIAL_A_LANE] == $past(r.shift_a[14])) else $error("serial shift wrong");
    ser_flag_end_a: assert property (r.mode == MODE_SER && !r.cs_s2 && !cs_fall && rd_fall // [RULE_10]
        && r.fall_count == SERIAL_LAST_FALL |=> !first_channel_flag_o) else $error("flag not dropped");
    par_flag_next_a: assert property (r.mode == MODE_PAR && !r.cs_s2 && rd_fall && r.flag // [RULE_11]
        && !(fifo_valid && word.channel_one) |=> !first_channel_flag_o) else $error("flag held too long");
    ref_follow_a: assert property ($rose(ref_select_i) ##1 ref_select_i[*3] |-> // [RULE_08]
        internal_ref_en_o) else $error("reference enable late");
endmodule
`default_nettype wire

// ---- design/conv_port_pkg.sv ----
// Shared constants and types for the conversion result output port.
// Assumes one core clock; host pins arrive asynchronous to it.
package conv_port_pkg;

    // ************************************************************
    // Sizes and pin lanes
    // ************************************************************
    localparam int RESULT_BITS = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int SERIAL_A_LANE = 7;
    localparam int SERIAL_B_LANE = 8;
    localparam int HIGH_FIRST_LANE = 14;
    localparam int BYTE_SEL_LANE = 15;
    localparam logic [4:0] SERIAL_LAST_FALL = 5'h0f;
    localparam logic [15:0] LANES_NONE = 16'h0000;
    localparam logic [15:0] LANES_ALL = 16'hffff;
    localparam logic [15:0] LANES_BYTE = 16'h00ff;
    localparam logic [15:0] LANES_SERIAL = 16'h0180;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {MODE_PAR, MODE_BYTE, MODE_SER} mode_t;

    typedef struct packed {
        logic channel_one;
        logic [RESULT_BITS-1:0] data;
    } result_word_t;

    localparam int WORD_BITS = $bits(result_word_t);

    typedef struct packed {
        logic cs_s1, cs_s2, cs_d;
        logic rd_s1, rd_s2, rd_d;
        logic sel_s1, sel_s2;
        logic hbf_s1, hbf_s2;
        logic bsel_s1, bsel_s2;
        logic ref_s1, ref_s2;
        mode_t mode;
        logic phase;
        logic load_b;
        logic [4:0] fall_count;
        logic [RESULT_BITS-1:0] shift_a;
        logic [RESULT_BITS-1:0] shift_b;
        logic [RESULT_BITS-1:0] bus;
        logic [RESULT_BITS-1:0] bus_oe;
        logic flag;
        logic flag_oe;
        logic ref_en;
    } port_state_t;

    // Select and strobe synchronisers start at their idle level, so no false select after reset
    localparam port_state_t PORT_STATE_RESET = '{
        cs_s1: 1'b1,
        cs_s2: 1'b1,
        cs_d: 1'b1,
        rd_s1: 1'b1,
        rd_s2: 1'b1,
        rd_d: 1'b1,
        mode: MODE_PAR,
        default: '0
    };

endpackage

// ---- design/result_fifo.sv ----
// Result FIFO with valid/ready on both sides.
// Assumes writer and reader on the same clock; read data falls through.
`timescale 1ns/100ps
`default_nettype none
module result_fifo
    import conv_port_pkg::*;
#(
    parameter int WIDTH = WORD_BITS,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
        logic full;
        logic ready;
    } fifo_state_t;

    fifo_state_t r, next_r;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign push = in_valid_i && r.ready;
    assign pop = out_ready_i && (r.count != '0);
    // Ready straight from a flop; low during reset
    assign in_ready_o = r.ready;
    assign out_valid_o = (r.count != '0);
    assign out_data_o = mem[r.rptr];

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.wptr = r.wptr + 1'b1;
        end
        if (pop) begin
            next_r.rptr = r.rptr + 1'b1;
        end
        next_r.count = r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_r.full = (next_r.count == (AW+1)'(DEPTH));
        next_r.ready = !next_r.full;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[r.wptr] <= in_data_i;
        end
    end

    fifo_count_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        r.count <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// ---- sim/host_model.sv ----
// Host-side model that reads conversion results over the port pins.
// Assumes the bench resolves the shared pin levels and calls these tasks.
`timescale 1ns/100ps
`default_nettype none
module host_model
    import conv_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic [RESULT_BITS-1:0] bus_i,
    input wire logic [RESULT_BITS-1:0] bus_oe_i,
    input wire logic flag_i,
    output logic cs_n_o,
    output logic read_strobe_o,
    output logic interface_select_o,
    output logic [RESULT_BITS-1:0] pins_o
);
    initial begin
        cs_n_o = 1'b1;
        read_strobe_o = 1'b1;
        interface_select_o = 1'b0;
        pins_o = '0;
    end

    // ************************************************************
    // Host pin tasks
    // ************************************************************
    task automatic set_mode(input logic strap, input logic bsel, input logic hbf);
        @(posedge clk_i);
        interface_select_o <= strap;
        pins_o <= {bsel, hbf, 14'h0000};
        read_strobe_o <= ~(strap & ~bsel);
        repeat (8) @(posedge clk_i);
    endtask

    task automatic select(input logic on);
        @(posedge clk_i);
        cs_n_o <= ~on;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic strobe(output logic [15:0] d, output logic [15:0] oe, output logic f);
        @(posedge clk_i);
        read_strobe_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        d = bus_i;
        oe = bus_oe_i;
        f = flag_i;
        @(posedge clk_i);
        read_strobe_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask

    // Serial clock idles low; only toggles inside the frame
    task automatic serial_frame(output logic [15:0] a, output logic [15:0] b, output logic [15:0] oe,
                                output logic f0, output logic f1);
        select(1'b1);
        @(negedge clk_i);
        f0 = flag_i;
        oe = bus_oe_i;
        for (int i = 15; i >= 0; i--) begin
            @(negedge clk_i);
            a[i] = bus_i[SERIAL_A_LANE];
            b[i] = bus_i[SERIAL_B_LANE];
            @(posedge clk_i);
            read_strobe_o <= 1'b1;
            repeat (6) @(posedge clk_i);
            read_strobe_o <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        f1 = flag_i;
        select(1'b0);
    endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the conversion result output port.
// Assumes host_model drives the host pins; the bench feeds results.
`timescale 1ns/100ps
`default_nettype none
module tb
    import conv_port_pkg::*;
;
    logic clk_i, arst_n_i, ref_select, result_valid, ready, flag, flag_oe, ref_en, cs_n, rd, strap;
    logic [15:0] dev_bus, dev_oe, host_pins, pin_level, d, d2, oe, b;
    logic f, f1;
    result_word_t result_word;
    int failures = 0;
    int tests_run = 0;

    assign pin_level = (dev_bus & dev_oe) | (host_pins & ~dev_oe);

    conv_result_port conv_result_port_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n),
        .read_strobe_i(rd), .interface_select_i(strap), .ref_select_i(ref_select),
        .parallel_output_bus_i(pin_level), .parallel_output_bus_o(dev_bus),
        .parallel_output_bus_oe_o(dev_oe), .first_channel_flag_o(flag),
        .first_channel_flag_oe_o(flag_oe), .internal_ref_en_o(ref_en),
        .result_valid_i(result_valid), .result_ready_o(ready), .result_i(result_word));

    host_model host_model_inst (.clk_i(clk_i), .bus_i(pin_level), .bus_oe_i(dev_oe), .flag_i(flag),
        .cs_n_o(cs_n), .read_strobe_o(rd), .interface_select_o(strap), .pins_o(host_pins));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic push(input logic ch, input logic [15:0] v);
        int n;
        n = 0;
        @(posedge clk_i);
        result_valid <= 1'b1;
        result_word <= '{channel_one: ch, data: v};
        @(negedge clk_i);
        while (ready !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 200) begin
            failures++;
        end
        @(posedge clk_i);
        result_valid <= 1'b0;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_idle_ref;
        @(negedge clk_i);
        check("oe_idle", dev_oe, 16'h0000);
        check("flag_oe_idle", flag_oe, 1'b0);
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk_i);
            ref_select <= v[0];
            repeat (6) @(negedge clk_i);
            check("ref_en", ref_en, v[0]);
        end
        $display("test idle_ref done");
    endtask

    task automatic test_parallel;
        host_model_inst.set_mode(1'b0, 1'b0, 1'b0);
        push(1'b1, 16'ha5c3);
        push(1'b0, 16'h3c5a);
        host_model_inst.select(1'b1);
        host_model_inst.strobe(d, oe, f);
        check("par_data0", d, 16'ha5c3);
        check("par_oe", oe, 16'hffff);
        check("par_flag0", f, 1'b1);
        host_model_inst.strobe(d, oe, f);
        check("par_data1", d, 16'h3c5a);
        check("par_flag1", f, 1'b0);
        @(negedge clk_i);
        check("par_oe_rd_high", dev_oe, 16'h0000);
        host_model_inst.select(1'b0);
        check("par_flag_oe_off", flag_oe, 1'b0);
        $display("test parallel done");
    endtask

    task automatic test_byte;
        for (int h = 0; h < 2; h++) begin
            host_model_inst.set_mode(1'b1, 1'b1, h[0]);
            push(1'b0, 16'hbe1f);
            host_model_inst.select(1'b1);
            host_model_inst.strobe(d, oe, f);
            host_model_inst.strobe(d2, oe, f);
            host_model_inst.select(1'b0);
            check("byte_first", d[7:0], h ? 8'hbe : 8'h1f);
            check("byte_second", d2[7:0], h ? 8'h1f : 8'hbe);
            check("byte_oe", oe, 16'h00ff);
        end
        $display("test byte done");
    endtask

    task automatic test_serial;
        host_model_inst.set_mode(1'b1, 1'b0, 1'b0);
        push(1'b1, 16'hc0a5);
        push(1'b0, 16'h5a3c);
        host_model_inst.serial_frame(d, b, oe, f, f1);
        check("ser_a", d, 16'hc0a5);
        check("ser_b", b, 16'h5a3c);
        check("ser_oe", oe, 16'h0180);
        check("ser_flag_start", f, 1'b1);
        check("ser_flag_end", f1, 1'b0);
        $display("test serial done");
    endtask

    // Source fills while the host stalls, then the host drains it
    task automatic test_fill_drain;
        // Byte select held high: strap low must still give parallel mode
        host_model_inst.set_mode(1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 32; i++) begin
            push(1'b0, 16'(i * 16'h0811));
        end
        repeat (2) @(negedge clk_i);
        check("ready_full", ready, 1'b0);
        host_model_inst.select(1'b1);
        for (int i = 0; i < 33; i++) begin
            host_model_inst.strobe(d, oe, f);
            check("drain_data", d, i < 32 ? 16'(i * 16'h0811) : 16'h0000);
            check("drain_oe", oe, 16'hffff);
        end
        host_model_inst.select(1'b0);
        check("ready_empty", ready, 1'b1);
        $display("test fill_drain done");
    endtask

    // ************************************************************
    // Clock, reset, sequence and watchdog
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial begin
        arst_n_i = 1'b0;
        ref_select = 1'b0;
        result_valid = 1'b0;
        result_word = '0;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        test_idle_ref();
        test_parallel();
        test_byte();
        test_serial();
        test_fill_drain();
        report_and_stop();
    end

    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
